// ===== rtl/swt_sleep_timer.v
`timescale 1ns/1ns
`include "swt_consts.vh"

module swt_sleep_timer (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        tick_en,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  input  wire        timer_wake_en,
  input  wire        cmp64_en,
  input  wire        sleep_enter,
  input  wire [63:0] rtc_count,
  input  wire        pin_wake,
  output wire        asleep,
  output wire        wake_req,
  output reg         tile_clk_gate,
  output reg         regulator_mod
);

  // Sequencer states as seen by this block; the others live elsewhere
  localparam [0:0] ST_AWAKE  = 1'b0;
  localparam [0:0] ST_ASLEEP = 1'b1;

  // Register selects returned by the address decoder
  localparam [1:0] SEL_NONE = 2'b00;
  localparam [1:0] SEL_LO   = 2'b01;
  localparam [1:0] SEL_HI   = 2'b10;
  localparam [1:0] SEL_CFG  = 2'b11;

  // Stored wake-up time, two 32-bit words
  reg  [31:0] wake_lo_q;
  reg  [31:0] wake_hi_q;

  // Sleeping-state configuration fields
  reg  [4:0]  dwell_q;
  reg         tile_gate_q;
  reg         mod_q;

  // Sequencer state and dwell tracking
  reg  [0:0]  state_q;
  reg  [0:0]  state_d;
  reg  [31:0] dwell_cnt_q;
  reg  [31:0] dwell_cnt_d;
  reg         dwell_done_q;
  reg         dwell_done_d;

  // Next values of the registered outputs
  reg  [31:0] rdata_d;
  reg         tile_gate_d;
  reg         mod_d;

  // Decoded strobes, compare results and views
  wire [1:0]  wr_sel;
  wire [1:0]  rd_sel;
  wire        in_sleep;
  wire        timer_hit;
  wire        wake_cond;
  wire [31:0] dwell_last;
  wire [31:0] cfg_view;

  // Map a byte offset onto one of the three registers
  function [1:0] swt_decode;
    input [7:0] addr;
    begin
      case (addr)
        `SWT_OFS_WAKE_LO: swt_decode = SEL_LO;
        `SWT_OFS_WAKE_HI: swt_decode = SEL_HI;
        `SWT_OFS_SLP_CFG: swt_decode = SEL_CFG;
        default:          swt_decode = SEL_NONE;
      endcase
    end
  endfunction

  // Counter at or past the wake time; high word only counts when wide
  function swt_reached;
    input [63:0] count;
    input [31:0] lo;
    input [31:0] hi;
    input        wide;
    begin
      if (wide) begin
        swt_reached = (count >= {hi, lo});
      end else begin
        swt_reached = (count[31:0] >= lo);
      end
    end
  endfunction

  // Shared decode for both strobes; unmapped offsets select nothing
  assign wr_sel = reg_wr ? swt_decode(reg_addr) : SEL_NONE;
  assign rd_sel = reg_rd ? swt_decode(reg_addr) : SEL_NONE;

  // Sleeping flag for the rest of the logic
  assign in_sleep = (state_q == ST_ASLEEP);
  assign asleep   = in_sleep;

  // Dwell limit is 2^n cycles, so the last count is 2^n - 1
  assign dwell_last = (32'h0000_0001 << dwell_q) - 32'h0000_0001;

  // Timer compare, width per comparison setting
  assign timer_hit = swt_reached(rtc_count, wake_lo_q, wake_hi_q, cmp64_en);

  // Timer only counts as a cause while enabled; the pin always does
  assign wake_cond = (timer_wake_en & timer_hit) | pin_wake;

  // Wake only from the sleeping state once the dwell has run out
  assign wake_req = in_sleep & dwell_done_q & wake_cond;

  // Readback image of the sleeping-state register, reserved bits zero
  assign cfg_view = {11'h000, dwell_q, 1'b0, tile_gate_q, 4'h0, mod_q, 9'h000};

  // Low wake-time word
  always @(posedge core_clk) begin
    if (!rst_n) begin
      wake_lo_q <= `SWT_WAKE_RST;
    end else if (wr_sel == SEL_LO) begin
      wake_lo_q <= reg_wdata;
    end
  end

  // High wake-time word, kept even while 32-bit compare is in use
  always @(posedge core_clk) begin
    if (!rst_n) begin
      wake_hi_q <= `SWT_WAKE_RST;
    end else if (wr_sel == SEL_HI) begin
      wake_hi_q <= reg_wdata;
    end
  end

  // Sleeping-state configuration; reserved bits are dropped
  always @(posedge core_clk) begin
    if (!rst_n) begin
      dwell_q     <= `SWT_DWELL_RST;
      tile_gate_q <= `SWT_GATE_RST;
      mod_q       <= `SWT_MOD_RST;
    end else if (wr_sel == SEL_CFG) begin
      dwell_q     <= reg_wdata[`SWT_DWELL_MSB:`SWT_DWELL_LSB];
      tile_gate_q <= reg_wdata[`SWT_TILE_GATE_BIT];
      mod_q       <= reg_wdata[`SWT_MOD_BIT];
    end
  end

  // Read mux; data holds until the next read strobe
  always @* begin
    rdata_d = reg_rdata;
    case (rd_sel)
      SEL_LO:  rdata_d = wake_lo_q;
      SEL_HI:  rdata_d = wake_hi_q;
      SEL_CFG: rdata_d = cfg_view;
      default: begin
        if (reg_rd) begin
          rdata_d = 32'h0000_0000;
        end
      end
    endcase
  end

  // Read data register
  always @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // Sequencer next state and dwell counting on the active clock's enable
  always @* begin
    state_d      = state_q;
    dwell_cnt_d  = dwell_cnt_q;
    dwell_done_d = dwell_done_q;
    case (state_q)
      ST_AWAKE: begin
        if (sleep_enter) begin
          state_d      = ST_ASLEEP;
          dwell_cnt_d  = 32'h0000_0000;
          dwell_done_d = 1'b0;
        end
      end
      ST_ASLEEP: begin
        if (wake_req) begin
          state_d = ST_AWAKE;
        end else if (tick_en && !dwell_done_q) begin
          if (dwell_cnt_q == dwell_last) begin
            dwell_done_d = 1'b1;
          end else begin
            dwell_cnt_d = dwell_cnt_q + 32'h0000_0001;
          end
        end
      end
      default: begin
        state_d = ST_AWAKE;
      end
    endcase
  end

  // Sequencer state registers
  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_q      <= ST_AWAKE;
      dwell_cnt_q  <= 32'h0000_0000;
      dwell_done_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      dwell_cnt_q  <= dwell_cnt_d;
      dwell_done_q <= dwell_done_d;
    end
  end

  // Sleeping-state settings reach the registered outputs one cycle behind the asleep state
  always @* begin
    tile_gate_d = in_sleep & tile_gate_q;
    mod_d       = in_sleep ? mod_q : `SWT_MOD_PWM;
  end

  // Output registers; awake default is tile clock on and PWM
  always @(posedge core_clk) begin
    if (!rst_n) begin
      tile_clk_gate <= `SWT_GATE_RST;
      regulator_mod <= `SWT_MOD_PWM;
    end else begin
      tile_clk_gate <= tile_gate_d;
      regulator_mod <= mod_d;
    end
  end

endmodule

// ===== inc/swt_consts.vh
// Summary of operation
// - The low wake-time word takes effect only while timer wake is enabled and the sequencer sleeps.
// - The high wake-time word is ignored unless 64-bit comparison is enabled.
// - The sleeping state is left only once the minimum dwell has expired and a wake condition occurs.
// - Dwell cycles are counted on the currently enabled clock, which may be the slow oscillator.
// - The dwell is 2^n cycles from a five-bit field at bits 20:16, reset value 16.
// - Bit 14 set stops the processor-tile clock while sleeping; it resets to 0.
// - The sleeping-state supply and clock settings apply from one cycle after the sequencer enters sleep until one cycle after it leaves.
// - Bit 9 selects the analogue supply regulator modulation while sleeping; it resets to 0.
// - Modulation 0 is pulse-width, 1 is pulse-frequency.
// - 64-bit comparison is enabled only by a general-control bit written 1, default 0.
// - Timer wake is enabled only by a general-control bit written 1, default 0.
`ifndef SWT_CONSTS_VH
`define SWT_CONSTS_VH
`define SWT_OFS_WAKE_LO   8'h04
`define SWT_OFS_WAKE_HI   8'h08
`define SWT_OFS_SLP_CFG   8'h0C
`define SWT_DWELL_MSB     20
`define SWT_DWELL_LSB     16
`define SWT_TILE_GATE_BIT 14
`define SWT_MOD_BIT       9
`define SWT_DWELL_RST     5'h10
`define SWT_WAKE_RST      32'h0000_0000
`define SWT_GATE_RST      1'b0
`define SWT_MOD_RST       1'b0
`define SWT_CFG_MASK      32'h001F_4200
`define SWT_MOD_PWM       1'b0
`define SWT_MOD_PFM       1'b1
`endif

// ===== verif/swt_sva.sv
`timescale 1ns/1ns
module swt_sva (
  input wire        core_clk,
  input wire        rst_n,
  input wire [7:0]  reg_addr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        timer_wake_en,
  input wire        pin_wake,
  input wire        sleep_enter,
  input wire        asleep,
  input wire        wake_req,
  input wire        tile_clk_gate,
  input wire        regulator_mod
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Leaving the sleeping state takes one edge
  sequence s_drop; ##1 !asleep; endsequence
  property p_cfg; reg_rd && reg_addr == 8'h0C |=> (reg_rdata & 32'hFFE0_BDFF) == 0; endproperty
  a_cfg: assert property (p_cfg) else $error("reserved bits read back");
  property p_drop; wake_req |-> s_drop; endproperty
  a_drop: assert property (p_drop) else $error("stayed asleep");
  property p_wslp; wake_req |-> asleep; endproperty
  a_wslp: assert property (p_wslp) else $error("wake while awake");
  property p_ent; sleep_enter && !asleep |=> asleep; endproperty
  a_ent: assert property (p_ent) else $error("no sleep entry");
  property p_dw; $rose(asleep) |-> !wake_req; endproperty
  a_dw: assert property (p_dw) else $error("dwell skipped");
  property p_en; asleep && !timer_wake_en && !pin_wake |-> !wake_req; endproperty
  a_en: assert property (p_en) else $error("wake without cause");
  property p_awk; !$past(asleep) |-> !tile_clk_gate && !regulator_mod; endproperty
  a_awk: assert property (p_awk) else $error("sleep settings while awake");
  property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind swt_sleep_timer swt_sva u_sva (.*);

// ===== verif/swt_sleep_timer_tb_top.sv
`timescale 1ns/1ns
module swt_sleep_timer_tb_top;
  logic        core_clk = 0, rst_n = 0, tick_en = 1, reg_wr = 0, reg_rd = 0, pin_wake = 0;
  logic        timer_wake_en = 0, cmp64_en = 0, sleep_enter = 0;
  logic [7:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [63:0] rtc_count = 0;
  logic        asleep, wake_req, tile_clk_gate, regulator_mod;
  int          errors = 0, checks = 0;
  swt_sleep_timer u_swt_sleep_timer (.*);
  always #20 core_clk = ~core_clk;
  task chk(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %0t got %h exp %h", $time, g, e);
    end
  endtask
  task summarize;
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge core_clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge core_clk) reg_wr = 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge core_clk) {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge core_clk) reg_rd = 0;
    chk(reg_rdata, e);
  endtask
  // Pulse entry, then wait 20 cycles; with ticks enabled the 4-tick dwell runs out, and any wake cause is left as it is
  task slp;
    @(negedge core_clk) sleep_enter = 1;
    @(negedge core_clk) sleep_enter = 0;
    repeat (20) @(negedge core_clk);
  endtask
  // Bounded wait for the sequencer to leave the sleeping state
  task wt;
    repeat (40) if (asleep === 1'b1) @(negedge core_clk);
    chk(asleep, 0);
    if (asleep !== 1'b0) summarize;
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    rst_n = 1;
    rd(8'h0C, 32'h0010_0000);
    rd(8'h04, 32'h0000_0000);
    rd(8'h08, 32'h0000_0000);
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, 32'h001F_4200);
    wr(8'h0C, 32'h0002_4200);
    wr(8'h04, 32'h0000_0064);
    wr(8'h08, 32'h0000_0001);
    {timer_wake_en, cmp64_en, rtc_count} = {2'b11, 64'h0000_0000_0000_00C8};
    slp;
    chk({asleep, tile_clk_gate, regulator_mod}, 3'b111);
    rtc_count = 64'h0000_0001_0000_0064;
    wt;
    @(negedge core_clk) chk({tile_clk_gate, regulator_mod}, 2'b00);
    timer_wake_en = 0;
    slp;
    chk(asleep, 1);
    pin_wake = 1;
    wt;
    // Stopped sleep clock: pin held high, yet no wake until 4 ticks pass
    tick_en = 0;
    slp;
    chk(asleep, 1);
    chk(wake_req, 0);
    @(negedge core_clk) tick_en = 1;
    repeat (4) @(negedge core_clk);
    chk(wake_req, 1);
    wt;
    summarize;
  end
endmodule
